// [nsr_pkg.sv]
// Purpose: Shared constants and types for the network status report block
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes:   Bit positions follow the status register layout
package nsr_pkg;

  localparam logic [11:0] NSR_STATUS_ADDR  = 12'h000;
  localparam logic [11:0] NSR_TXPOLL_ADDR  = 12'h004;
  localparam logic [11:0] NSR_RXPOLL_ADDR  = 12'h008;
  localparam logic [11:0] NSR_TXSTATE_ADDR = 12'h00c;

  localparam int NSR_TRANSMIT_COMPLETE_FLAG = 0;
  localparam int NSR_TRANSMIT_STOPPED_OR_STATE = 1;
  localparam int NSR_TRANSMIT_BUFFER_UNAVAILABLE_FLAG = 2;
  localparam int NSR_TXJT = 3;
  localparam int NSR_TRANSMIT_UNDERRUN_FLAG = 5;
  localparam int NSR_RECEIVE_COMPLETE_FLAG = 6;
  localparam int NSR_RECEIVE_BUFFER_UNAVAILABLE_FLAG = 7;
  localparam int NSR_RECEIVE_STOPPED_OR_STATE = 8;
  localparam int NSR_RECEIVE_WATCHDOG_FLAG = 9;
  localparam int NSR_TRANSMIT_EARLY_FLAG = 10;
  localparam int NSR_GPT  = 11;
  localparam int NSR_LCI  = 12;
  localparam int NSR_SBE  = 13;
  localparam int NSR_ERI  = 14;
  localparam int NSR_AIS  = 15;
  localparam int NSR_NIS  = 16;
  localparam int NSR_RXST_LO = 17;
  localparam int NSR_TXST_LO = 20;
  localparam int NSR_BET_LO  = 23;

  localparam logic [15:0] NSR_FLAG_MASK = 16'h7fef;
  localparam logic [15:0] NSR_NORM_MASK = 16'h0045;
  localparam logic [15:0] NSR_ABN_MASK  = 16'h2faa;
  localparam logic [15:0] NSR_FLAG_RST  = 16'h0000;
  localparam logic [2:0]  NSR_BET_RST   = 3'h0;

  localparam logic [2:0] NSR_BET_PARITY = 3'h0;
  localparam logic [2:0] NSR_BET_MABORT = 3'h1;
  localparam logic [2:0] NSR_BET_SABORT = 3'h2;

  // Process state codes as they appear in the status word
  localparam logic [2:0] NSR_ST_STOP  = 3'h0;
  localparam logic [2:0] NSR_ST_FETCH = 3'h1;
  localparam logic [2:0] NSR_ST_C2    = 3'h2;
  localparam logic [2:0] NSR_ST_MOVE  = 3'h3;
  localparam logic [2:0] NSR_ST_CLOWN = 3'h4;
  localparam logic [2:0] NSR_ST_C5    = 3'h5;
  localparam logic [2:0] NSR_ST_C6    = 3'h6;
  localparam logic [2:0] NSR_ST_C7    = 3'h7;

  typedef struct packed {
    logic tx_complete;
    logic tx_stopped;
    logic tx_buf_unavail;
    logic tx_jabber;
    logic tx_underrun;
    logic rx_complete;
    logic rx_buf_unavail;
    logic rx_stopped;
    logic rx_watchdog;
    logic tx_early;
    logic timer_expired;
    logic link_change;
    logic bus_error;
    logic early_receive;
  } nsr_event_s;

endpackage

// [nsr_status.sv]
// Purpose: Network status report register with event flags, summaries and process states
// Assumes: Engines give one-cycle event pulses and 3-bit state codes on SYS_CLK
// Notes:   Flags clear by writing one; an event in the clearing cycle wins
//
// How it works
// - Transmit state shows 010 setup, 011 data move
// - Transmit state 100,101,110,111 close/wait/end/suspend
// - Receive state 000..011 stop/fetch/wait/move
// - Receive state 100..111 clear/status/suspend/purge
// - Normal summary from tx complete, tx unavail, rx complete
// - Abnormal summary from the nine abnormal flags
// - Early receive event sets its flag
// - Bus error sets flag, records error type
// - Link status change sets its flag
// - Timer expiry sets its flag
// - Full packet in FIFO sets transmit early
// - Transmit complete clears transmit early flag
// - Receive watchdog expiry sets its flag
// - Receive stop entry sets its flag
// - Frame written to host sets receive complete
// - Underrun sets flag, suspends, marks descriptor
// - Jabber sets flag, stops, marks descriptor
// - Host-owned transmit descriptor sets unavailable, suspends
// - Transmit stop entry sets its flag
// - Frame sent with status sets transmit complete
// - Poll write makes engine poll descriptor
// - Error type 000 parity, 001 master, 010 slave
`timescale 1ns/1ps
`default_nettype none

module nsr_status
(
  input  wire logic              SYS_CLK,
  input  wire logic              RESETN,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [11:0]       PADDR,
  input  wire logic [31:0]       PWDATA,
  input  wire logic [3:0]        PSTRB,
  output logic [31:0]            PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  input  wire nsr_pkg::nsr_event_s EVENTS,
  input  wire logic [2:0]        BUS_ERROR_TYPE,
  input  wire logic [2:0]        TX_ENGINE_STATE,
  input  wire logic [2:0]        RX_ENGINE_STATE,
  output logic                   TX_POLL_DEMAND,
  output logic                   RX_POLL_DEMAND,
  output logic                   TX_SUSPEND_REQ,
  output logic                   TX_STOP_REQ,
  output logic                   RX_SUSPEND_REQ,
  output logic                   TX_DESC_UNDERRUN_ERROR,
  output logic                   TX_DESC_JABBER_TIMEOUT
);
  import nsr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Layout checks

  // The status word is packed from fixed positions; a package edit that
  // moves one field onto another would corrupt reads silently, so refuse it
  if (NSR_AIS != NSR_ERI + 1 || NSR_NIS != NSR_AIS + 1)
  begin : g_bad_summary
    $error("Summary bits must follow the event flags");
  end

  if (NSR_RXST_LO != NSR_NIS + 1 || NSR_TXST_LO != NSR_RXST_LO + 3)
  begin : g_bad_state
    $error("Process state fields must follow the summary bits");
  end

  if (NSR_BET_LO != NSR_TXST_LO + 3 || NSR_BET_LO + 3 > 32)
  begin : g_bad_type
    $error("Error type field misplaced");
  end

  if ((NSR_NORM_MASK & NSR_ABN_MASK) != 16'h0000)
  begin : g_bad_split
    $error("A flag cannot feed both summaries");
  end

  if (((NSR_NORM_MASK | NSR_ABN_MASK) & ~NSR_FLAG_MASK) != 16'h0000)
  begin : g_bad_cover
    $error("Summaries may only read latched flag bits");
  end

  if (NSR_FLAG_MASK[NSR_AIS])
  begin : g_bad_flags
    $error("Flag mask reaches the summary bits");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // One compare for every register decode, so all offsets match the same way
  function automatic logic reg_hit
  (
    input logic [11:0] addr,
    input logic [11:0] target
  );
    return addr == target;
  endfunction

  // Assemble the readable word; summary bits are derived, never stored,
  // so a host write can never leave a summary out of step with its flags
  function automatic logic [31:0] pack_status
  (
    input logic [15:0] flags,
    input logic        abn,
    input logic        norm,
    input logic [2:0]  rx_st,
    input logic [2:0]  tx_st,
    input logic [2:0]  err_type
  );
    logic [31:0] w;
    w                                  = 32'h0000_0000;
    w[15:0]                            = flags;
    w[NSR_AIS]                         = abn;
    w[NSR_NIS]                         = norm;
    w[NSR_RXST_LO+2:NSR_RXST_LO]       = rx_st;
    w[NSR_TXST_LO+2:NSR_TXST_LO]       = tx_st;
    w[NSR_BET_LO+2:NSR_BET_LO]         = err_type;
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  // Every access completes in its first access cycle, so PREADY never drops.
  // Poll demands reach the engines one cycle after the access edge.

  logic        wr_en;
  logic        rd_en;
  logic        hit_status;
  logic        hit_txpoll;
  logic        hit_rxpoll;
  logic        hit_txst;
  logic        mapped;
  logic [15:0] flag_r;
  logic [15:0] flag_nxt;
  logic [15:0] set_vec;
  logic [15:0] clr_vec;
  logic [2:0]  bet_r;
  logic [2:0]  tx_state_r;
  logic [2:0]  rx_state_r;
  logic        normal_sum;
  logic        abnormal_sum;
  logic [31:0] status_word;
  logic [31:0] rdata_nxt;

  assign wr_en      = PSEL && PENABLE && PWRITE;
  assign rd_en      = PSEL && PENABLE && !PWRITE;
  assign hit_status = reg_hit(PADDR, NSR_STATUS_ADDR);
  assign hit_txpoll = reg_hit(PADDR, NSR_TXPOLL_ADDR);
  assign hit_rxpoll = reg_hit(PADDR, NSR_RXPOLL_ADDR);
  assign hit_txst   = reg_hit(PADDR, NSR_TXSTATE_ADDR);
  assign mapped     = hit_status || hit_txpoll || hit_rxpoll || hit_txst;
  // Zero-wait slave; unmapped addresses answer with an error
  assign PREADY     = 1'b1;
  assign PSLVERR    = PSEL && PENABLE && !mapped;

  ////////////////////////////////////////////////////////////////////////////
  // Event flags

  // Each engine event is a one-cycle pulse that latches its flag until the
  // host writes a one to it (transmit early also clears on transmit complete); a pulse in the host clearing cycle still lands.
  always_comb
  begin
    set_vec           = 16'h0000;
    set_vec[NSR_TRANSMIT_COMPLETE_FLAG] = EVENTS.tx_complete;
    set_vec[NSR_TRANSMIT_STOPPED_OR_STATE] = EVENTS.tx_stopped;
    set_vec[NSR_TRANSMIT_BUFFER_UNAVAILABLE_FLAG] = EVENTS.tx_buf_unavail;
    set_vec[NSR_TXJT] = EVENTS.tx_jabber;
    set_vec[NSR_TRANSMIT_UNDERRUN_FLAG] = EVENTS.tx_underrun;
    set_vec[NSR_RECEIVE_COMPLETE_FLAG] = EVENTS.rx_complete;
    set_vec[NSR_RECEIVE_BUFFER_UNAVAILABLE_FLAG] = EVENTS.rx_buf_unavail;
    set_vec[NSR_RECEIVE_STOPPED_OR_STATE] = EVENTS.rx_stopped;
    set_vec[NSR_RECEIVE_WATCHDOG_FLAG] = EVENTS.rx_watchdog;
    set_vec[NSR_TRANSMIT_EARLY_FLAG] = EVENTS.tx_early;
    set_vec[NSR_GPT]  = EVENTS.timer_expired;
    set_vec[NSR_LCI]  = EVENTS.link_change;
    set_vec[NSR_SBE]  = EVENTS.bus_error;
    set_vec[NSR_ERI]  = EVENTS.early_receive;
  end

  // Only the low byte lanes carry flag bits
  assign clr_vec = (wr_en && hit_status) ?
                   (PWDATA[15:0] & {{8{PSTRB[1]}}, {8{PSTRB[0]}}} & NSR_FLAG_MASK) :
                   16'h0000;

  always_comb
  begin
    flag_nxt = (flag_r & ~clr_vec) | set_vec;
    // Completion retires the early notice; a same-cycle early event still loses
    if (EVENTS.tx_complete)
    begin
      flag_nxt[NSR_TRANSMIT_EARLY_FLAG] = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      flag_r <= NSR_FLAG_RST;
    else
      flag_r <= flag_nxt & NSR_FLAG_MASK;
  end

  // Type is captured with each error so it stays valid while the flag is set
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      bet_r <= NSR_BET_RST;
    else if (EVENTS.bus_error)
      bet_r <= BUS_ERROR_TYPE;
  end

  assign normal_sum   = |(flag_r & NSR_NORM_MASK);
  assign abnormal_sum = |(flag_r & NSR_ABN_MASK);

  ////////////////////////////////////////////////////////////////////////////
  // Process state fields

  // The engine codes are copied straight through; one register stage keeps
  // the read path off the engines' own state logic, at one cycle of lag.
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      tx_state_r <= NSR_ST_STOP;
      rx_state_r <= NSR_ST_STOP;
    end
    else
    begin
      tx_state_r <= TX_ENGINE_STATE;
      rx_state_r <= RX_ENGINE_STATE;
    end
  end

  always_comb
  begin
    status_word = pack_status(flag_r, abnormal_sum, normal_sum, rx_state_r, tx_state_r, bet_r);
  end

  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    if (hit_status)
      rdata_nxt = status_word;
    else if (hit_txst)
      rdata_nxt = {29'h0000_0000, tx_state_r};
  end

  // Read data stands only in a read access cycle and is zero otherwise,
  // so an idle bus never shows a stale status word
  assign PRDATA = (rd_en) ? rdata_nxt : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Poll demands and engine control

  // These are plain requests to the engines; the engines make the actual
  // state change and report it back through the state codes above.
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      TX_POLL_DEMAND <= 1'b0;
      RX_POLL_DEMAND <= 1'b0;
    end
    else
    begin
      TX_POLL_DEMAND <= wr_en && hit_txpoll;
      RX_POLL_DEMAND <= wr_en && hit_rxpoll;
    end
  end

  // Suspend requests hold until a poll (or new frame for receive) restarts
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      TX_SUSPEND_REQ <= 1'b0;
    else if (EVENTS.tx_buf_unavail || EVENTS.tx_underrun)
      TX_SUSPEND_REQ <= 1'b1;
    else if (wr_en && hit_txpoll)
      TX_SUSPEND_REQ <= 1'b0;
  end

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      RX_SUSPEND_REQ <= 1'b0;
    else if (EVENTS.rx_buf_unavail)
      RX_SUSPEND_REQ <= 1'b1;
    else if ((wr_en && hit_rxpoll) || EVENTS.rx_complete)
      RX_SUSPEND_REQ <= 1'b0;
  end

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      TX_STOP_REQ            <= 1'b0;
      TX_DESC_UNDERRUN_ERROR <= 1'b0;
      TX_DESC_JABBER_TIMEOUT <= 1'b0;
    end
    else
    begin
      TX_STOP_REQ            <= EVENTS.tx_jabber;
      TX_DESC_UNDERRUN_ERROR <= EVENTS.tx_underrun;
      TX_DESC_JABBER_TIMEOUT <= EVENTS.tx_jabber;
    end
  end

endmodule

`default_nettype wire

// [nsr_status_asserts.sv]
// Purpose: Port-level checks on the status report block
// Assumes: One clock domain, active-low reset
// Notes:   Bound to the design from tb_top
`timescale 1ns/1ps
`default_nettype none
module nsr_status_asserts
  import nsr_pkg::*;
(
  input wire logic              SYS_CLK,
  input wire logic              RESETN,
  input wire logic              PSEL,
  input wire logic              PENABLE,
  input wire logic              PWRITE,
  input wire logic [11:0]       PADDR,
  input wire logic [31:0]       PRDATA,
  input wire nsr_pkg::nsr_event_s EVENTS,
  input wire logic [2:0]        TX_ENGINE_STATE,
  input wire logic [2:0]        RX_ENGINE_STATE,
  input wire logic              TX_POLL_DEMAND,
  input wire logic              RX_POLL_DEMAND,
  input wire logic              TX_SUSPEND_REQ,
  input wire logic              TX_STOP_REQ,
  input wire logic              RX_SUSPEND_REQ,
  input wire logic              TX_DESC_UNDERRUN_ERROR,
  input wire logic              TX_DESC_JABBER_TIMEOUT
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  sequence s_rd;
    PSEL && PENABLE && !PWRITE && PADDR == NSR_STATUS_ADDR;
  endsequence
  sequence s_txpoll;
    PSEL && PENABLE && PWRITE && PADDR == NSR_TXPOLL_ADDR;
  endsequence
  sequence s_rxpoll;
    PSEL && PENABLE && PWRITE && PADDR == NSR_RXPOLL_ADDR;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  chk_norm_sum:
    assert property (s_rd |-> PRDATA[16] == |(PRDATA[15:0] & NSR_NORM_MASK)) else $error("nis");
  chk_abn_sum:
    assert property (s_rd |-> PRDATA[15] == |(PRDATA[15:0] & NSR_ABN_MASK)) else $error("ais");
  chk_tx_state:
    assert property (s_rd |-> PRDATA[22:20] == $past(TX_ENGINE_STATE)) else $error("tx state");
  chk_rx_state:
    assert property (s_rd |-> PRDATA[19:17] == $past(RX_ENGINE_STATE)) else $error("rx state");
  chk_jabber_stop:
    assert property (EVENTS.tx_jabber |=> TX_STOP_REQ && TX_DESC_JABBER_TIMEOUT) else $error("jab");
  chk_underrun_susp:
    assert property (EVENTS.tx_underrun |=> TX_SUSPEND_REQ && TX_DESC_UNDERRUN_ERROR)
      else $error("underrun");
  // Same-cycle bus accesses are excluded, although the event wins over a poll write and still sets the suspend
  chk_tx_unavail:
    assert property (EVENTS.tx_buf_unavail && !PSEL |=> TX_SUSPEND_REQ) else $error("tx susp");
  chk_rx_unavail:
    assert property (EVENTS.rx_buf_unavail && !EVENTS.rx_complete && !PSEL |=> RX_SUSPEND_REQ)
      else $error("rx susp");
  chk_tx_poll:
    assert property (s_txpoll |=> TX_POLL_DEMAND) else $error("tx poll");
  chk_rx_poll:
    assert property (s_rxpoll |=> RX_POLL_DEMAND) else $error("rx poll");
  chk_tx_resume:
    assert property (s_txpoll && !EVENTS.tx_buf_unavail && !EVENTS.tx_underrun
      |=> !TX_SUSPEND_REQ) else $error("tx resume");
endmodule
`default_nettype wire

// [nsr_host.sv]
// Purpose: Host software model issuing APB transfers
// Assumes: Transfers are serialised by the caller
// Notes:   Write data is inverted on release so stale values never look valid
`timescale 1ns/1ps
`default_nettype none
module nsr_host
(
  input  wire logic        clk,
  input  wire logic        pready,
  output logic             psel = 1'b0,
  output logic             penable = 1'b0,
  output logic             pwrite = 1'b0,
  output logic [11:0]      paddr = 12'h0,
  output logic [31:0]      pwdata = 32'h0,
  output logic [3:0]       pstrb = 4'h0
);
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// [tb_top.sv]
// Purpose: Random event and register traffic against the status block
// Assumes: Zero-wait APB slave, one-cycle event pulses
// Notes:   Flags and error type are mirrored in a software model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import nsr_pkg::*;
  logic SYS_CLK = 1'b0;
  logic RESETN = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, v, m, s;
  logic [3:0] pstrb;
  nsr_event_s ev = '0;
  logic [2:0] bet = 3'h0, txs = 3'h0, rxs = 3'h0, bet_m;
  logic [13:0] r;
  logic [14:0] flg, cm;
  logic [32:0] q[$];
  logic [32:0] e;
  int fail_count = 0, samples_checked = 0, cyc = 0;
  logic [31:0] rs = 32'd8799;
  initial forever #25 SYS_CLK = ~SYS_CLK;
  nsr_host host (.clk(SYS_CLK), .pready(pready), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
  nsr_status DUT (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .EVENTS(ev), .BUS_ERROR_TYPE(bet),
    .TX_ENGINE_STATE(txs), .RX_ENGINE_STATE(rxs), .TX_POLL_DEMAND(), .RX_POLL_DEMAND(),
    .TX_SUSPEND_REQ(), .TX_STOP_REQ(), .RX_SUSPEND_REQ(), .TX_DESC_UNDERRUN_ERROR(),
    .TX_DESC_JABBER_TIMEOUT());
  function logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  function logic [32:0] word();
    return {7'h0, bet_m, txs, rxs, |(flg & NSR_NORM_MASK[14:0]), |(flg & NSR_ABN_MASK[14:0]), flg};
  endfunction
  task tally_and_finish();
    $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge SYS_CLK)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fail_count++;
      tally_and_finish();
    end
    else if (psel && penable && !pwrite && pready)
    begin
      e = q.pop_front();
      samples_checked++;
      if ({pslverr, prdata} !== e)
      begin
        fail_count++;
        $display("ERROR t=%0t got %h exp %h", $time, {pslverr, prdata}, e);
      end
    end
  end
  initial
  begin
    flg = '0;
    bet_m = 3'h0;
    repeat (4) @(posedge SYS_CLK);
    RESETN <= 1'b1;
    q.push_back(word());
    host.xfer(1'b0, NSR_STATUS_ADDR, 32'h0, 4'hf);
    for (int i = 0; i < 60; i++)
    begin
      v = rnd();
      @(posedge SYS_CLK);
      ev <= nsr_event_s'(v[13:0]);
      txs <= v[22:20];
      rxs <= v[19:17];
      bet <= (v[31:30] == 2'h3) ? NSR_BET_PARITY : {1'b0, v[31:30]};
      @(posedge SYS_CLK);
      ev <= '0;
      r = {<<{v[13:0]}};
      if (r[12])
        bet_m = bet;
      flg = flg | {r[13:4], 1'b0, r[3:0]};
      // Completion in the same cycle wins over a new early-transmit event
      if (r[0])
        flg[10] = 1'b0;
      q.push_back(word());
      host.xfer(1'b0, NSR_STATUS_ADDR, 32'h0, 4'hf);
      m = rnd();
      s = rnd();
      cm = m[14:0] & {{7{s[1]}}, {8{s[0]}}};
      flg = flg & ~cm;
      host.xfer(1'b1, NSR_STATUS_ADDR, m, s[3:0]);
      q.push_back(word());
      host.xfer(1'b0, NSR_STATUS_ADDR, 32'h0, 4'hf);
      host.xfer(1'b1, v[0] ? NSR_TXPOLL_ADDR : NSR_RXPOLL_ADDR, m, 4'hf);
    end
    host.xfer(1'b1, 12'h010, 32'hffffffff, 4'hf);
    q.push_back({1'b1, 32'h0});
    host.xfer(1'b0, 12'h010, 32'h0, 4'hf);
    q.push_back(word());
    host.xfer(1'b0, NSR_STATUS_ADDR, 32'h0, 4'hf);
    tally_and_finish();
  end
endmodule
bind nsr_status nsr_status_asserts u_chk (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .EVENTS(EVENTS),
  .TX_ENGINE_STATE(TX_ENGINE_STATE), .RX_ENGINE_STATE(RX_ENGINE_STATE),
  .TX_POLL_DEMAND(TX_POLL_DEMAND), .RX_POLL_DEMAND(RX_POLL_DEMAND),
  .TX_SUSPEND_REQ(TX_SUSPEND_REQ), .TX_STOP_REQ(TX_STOP_REQ),
  .RX_SUSPEND_REQ(RX_SUSPEND_REQ), .TX_DESC_UNDERRUN_ERROR(TX_DESC_UNDERRUN_ERROR),
  .TX_DESC_JABBER_TIMEOUT(TX_DESC_JABBER_TIMEOUT));
`default_nettype wire
